// [logic/tmr_map.svh]
/*
 * register offsets, field positions, reset values and prescaler masks of the timer.
 * assumes a byte-addressed apb slave with one aligned 32-bit word per register.
 */
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TMR_OFF_CTRL_A 8'h00
`define TMR_OFF_CTRL_B 8'h04
`define TMR_OFF_COUNT 8'h08
`define TMR_OFF_CMP_A 8'h0c
`define TMR_OFF_CMP_B 8'h10
`define TMR_OFF_IRQ_EN 8'h14
`define TMR_OFF_FLAGS 8'h18
`define TMR_OFF_FLAG_CLR 8'h1c

// ****************************************************************
// field positions
// ****************************************************************
`define TMR_FOC_A_BIT 7
`define TMR_FOC_B_BIT 6
`define TMR_WGM2_BIT 3

// ****************************************************************
// reset values and counter limits
// ****************************************************************
`define TMR_BYTE_RST 8'h00
`define TMR_IRQ_RST 3'h0
`define TMR_MAX 8'hff
`define TMR_BOTTOM 8'h00

// ****************************************************************
// prescaler tap masks: divide by 8, 32, 64, 128, 256, 1024
// ****************************************************************
`define TMR_DIV8_MASK 10'h007
`define TMR_DIV32_MASK 10'h01f
`define TMR_DIV64_MASK 10'h03f
`define TMR_DIV128_MASK 10'h07f
`define TMR_DIV256_MASK 10'h0ff
`define TMR_DIV1024_MASK 10'h3ff

`endif

// [logic/tmr_pkg.sv]
/*
 * types of the timer: control register layouts, interrupt bit group, count direction.
 * assumes nothing beyond a systemverilog compiler.
 */
package tmr_pkg;

    typedef struct packed {
        logic [1:0] out_mode_a;
        logic [1:0] out_mode_b;
        logic [1:0] rsvd;
        logic [1:0] wave_mode_lo;
    } tmr_ctrl_a_s;

    typedef struct packed {
        logic force_cmp_a;
        logic force_cmp_b;
        logic [1:0] rsvd;
        logic wave_mode_msb;
        logic [2:0] clk_select;
    } tmr_ctrl_b_s;

    typedef struct packed {
        logic cmp_b;
        logic cmp_a;
        logic ovf;
    } tmr_irq_s;

    typedef enum logic {
        DIR_UP,
        DIR_DOWN
    } tmr_dir_e;

endpackage : tmr_pkg

// [logic/tmr_timer2.sv]
/*
 * 8-bit timer/counter with prescaler, two compare channels, waveform pins and
 * interrupt flags, reached over apb.
 * assumes a zero-wait apb master on pclk and that timer_src_clock is pclk itself.
 */
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "tmr_map.svh"

// Contract
// - force A strobe applies compare A action
// - force B strobe applies compare B action
// - force uses current mode, no flag/clear
// - force bits read zero, ignored in pwm
// - control b bits 5:4 read zero
// - clock select stops or divides timer clock
// - counter readable and writable any time
// - counter write blocks next tick match
// - both compare values checked every tick
// - matches set compare flags b and a
// - overflow flag, phase pwm sets at bottom, fast pwm at top
// - vector execution clears its flag
// - writing one clears a flag
// - request needs flag, enable, global enable
// - non-pwm output modes disconnect/toggle/clear/set
// - three mode bits pick sequence and top
module tmr_timer2 import tmr_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_irq_en,
    input wire logic [2:0] irq_ack,
    output logic [2:0] irq_req,
    output logic irq,
    output logic wave_out_a,
    output logic wave_oe_a,
    output logic wave_out_b,
    output logic wave_oe_b
);

    // ****************************************************************
    // state
    // ****************************************************************
    tmr_ctrl_a_s ctrl_a_q;
    tmr_ctrl_b_s ctrl_b_q;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] cmp_a_q;
    logic [7:0] cmp_b_q;
    tmr_irq_s irq_en_q;
    tmr_irq_s flags_q;
    tmr_irq_s flag_set;
    tmr_irq_s flag_clr;
    tmr_dir_e dir_q;
    tmr_dir_e dir_d;
    logic block_q;
    logic [9:0] presc_q;
    logic wave_a_q;
    logic wave_b_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    logic wr;
    logic sel_ca, sel_cb, sel_cnt, sel_oa, sel_ob, sel_ien, sel_flg, sel_clr;
    logic [31:0] rd_val;
    logic wr_cnt, force_a, force_b;
    logic [2:0] wgm;
    logic pwm, fast, phase, ctc;
    logic [7:0] top;
    logic tick, at_top, at_bot, top_ev;
    logic match_a, match_b, ovf_ev;
    logic [9:0] tap_mask;

    // ****************************************************************
    // apb decode and read data
    // ****************************************************************
    assign wr = psel && penable && pwrite;

    always_comb begin
        sel_ca = 1'b0;
        sel_cb = 1'b0;
        sel_cnt = 1'b0;
        sel_oa = 1'b0;
        sel_ob = 1'b0;
        sel_ien = 1'b0;
        sel_flg = 1'b0;
        sel_clr = 1'b0;
        rd_val = 32'h0000_0000;
        if (paddr == `TMR_OFF_CTRL_A) begin
            sel_ca = 1'b1;
            rd_val = {24'h00_0000, ctrl_a_q};
        end else if (paddr == `TMR_OFF_CTRL_B) begin
            sel_cb = 1'b1;
            rd_val = {24'h00_0000, ctrl_b_q}; // force and reserved bits are held at zero
        end else if (paddr == `TMR_OFF_COUNT) begin
            sel_cnt = 1'b1;
            rd_val = {24'h00_0000, count_q};
        end else if (paddr == `TMR_OFF_CMP_A) begin
            sel_oa = 1'b1;
            rd_val = {24'h00_0000, cmp_a_q};
        end else if (paddr == `TMR_OFF_CMP_B) begin
            sel_ob = 1'b1;
            rd_val = {24'h00_0000, cmp_b_q};
        end else if (paddr == `TMR_OFF_IRQ_EN) begin
            sel_ien = 1'b1;
            rd_val = {29'h0000_0000, irq_en_q};
        end else if (paddr == `TMR_OFF_FLAGS) begin
            sel_flg = 1'b1;
            rd_val = {29'h0000_0000, flags_q};
        end else if (paddr == `TMR_OFF_FLAG_CLR) begin
            sel_clr = 1'b1;
        end
    end

    // read data is captured in the setup phase, so the access phase never waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr_q <= !(sel_ca || sel_cb || sel_cnt || sel_oa || sel_ob || sel_ien || sel_flg || sel_clr);
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = pslverr_q;

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_q <= tmr_ctrl_a_s'(`TMR_BYTE_RST);
        end else if (wr && sel_ca) begin
            ctrl_a_q <= tmr_ctrl_a_s'({pwdata[7:4], 2'b00, pwdata[1:0]});
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_b_q <= tmr_ctrl_b_s'(`TMR_BYTE_RST);
        end else if (wr && sel_cb) begin
            ctrl_b_q.wave_mode_msb <= pwdata[`TMR_WGM2_BIT];
            ctrl_b_q.clk_select <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_a_q <= `TMR_BYTE_RST;
            cmp_b_q <= `TMR_BYTE_RST;
            irq_en_q <= `TMR_IRQ_RST;
        end else if (wr) begin
            if (sel_oa) begin
                cmp_a_q <= pwdata[7:0];
            end
            if (sel_ob) begin
                cmp_b_q <= pwdata[7:0];
            end
            if (sel_ien) begin
                irq_en_q <= tmr_irq_s'(pwdata[2:0]);
            end
        end
    end

    // ****************************************************************
    // mode decode
    // ****************************************************************
    assign wgm = {ctrl_b_q.wave_mode_msb, ctrl_a_q.wave_mode_lo};
    assign pwm = wgm[0];
    assign fast = wgm[1] && wgm[0];
    assign phase = wgm[0] && !wgm[1];
    assign ctc = wgm[1] && !wgm[0];
    assign top = (wgm[2] || ctc) ? cmp_a_q : `TMR_MAX;

    // strobes: software may still set them in pwm modes, and the pwm gate below ignores them there
    assign wr_cnt = wr && sel_cnt;
    assign force_a = wr && sel_cb && pwdata[`TMR_FOC_A_BIT];
    assign force_b = wr && sel_cb && pwdata[`TMR_FOC_B_BIT];

    // ****************************************************************
    // prescaler
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= 10'h000;
        end else begin
            presc_q <= presc_q + 10'h001;
        end
    end

    always_comb begin
        tap_mask = 10'h000;
        tick = 1'b0;
        case (ctrl_b_q.clk_select)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tap_mask = `TMR_DIV8_MASK;
            3'h3: tap_mask = `TMR_DIV32_MASK;
            3'h4: tap_mask = `TMR_DIV64_MASK;
            3'h5: tap_mask = `TMR_DIV128_MASK;
            3'h6: tap_mask = `TMR_DIV256_MASK;
            default: tap_mask = `TMR_DIV1024_MASK;
        endcase
        if (ctrl_b_q.clk_select > 3'h1) begin
            tick = (presc_q & tap_mask) == tap_mask;
        end
    end

    // ****************************************************************
    // counter
    // ****************************************************************
    assign at_top = count_q == top;
    assign at_bot = count_q == `TMR_BOTTOM;
    assign top_ev = tick && fast && at_top;
    assign match_a = tick && !block_q && !wr_cnt && (count_q == cmp_a_q);
    assign match_b = tick && !block_q && !wr_cnt && (count_q == cmp_b_q);

    always_comb begin
        count_d = count_q;
        dir_d = dir_q;
        ovf_ev = 1'b0;
        if (tick) begin
            if (phase) begin
                if (dir_q == DIR_UP) begin
                    if (at_top) begin
                        dir_d = DIR_DOWN;
                        count_d = count_q - 8'h01;
                    end else begin
                        count_d = count_q + 8'h01;
                    end
                end else if (at_bot) begin
                    dir_d = DIR_UP;
                    count_d = count_q + 8'h01;
                    ovf_ev = 1'b1;
                end else begin
                    count_d = count_q - 8'h01;
                end
            end else begin
                count_d = ((ctc || fast) && at_top) ? `TMR_BOTTOM : count_q + 8'h01;
                ovf_ev = fast ? at_top : (count_q == `TMR_MAX);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= `TMR_BYTE_RST;
        end else if (wr_cnt) begin
            count_q <= pwdata[7:0];
        end else begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= DIR_UP;
        end else if (!wr_cnt) begin
            dir_q <= dir_d;
        end
    end

    // a counter write masks the match of the following timer tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_q <= 1'b0;
        end else if (wr_cnt) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // ****************************************************************
    // waveform outputs
    // ****************************************************************
    function automatic logic wave_next(
        input logic cur,
        input logic [1:0] com,
        input logic is_pwm,
        input logic is_fast,
        input logic going_up,
        input logic match,
        input logic top_hit,
        input logic force_ev,
        input logic tog_ok
    );
        logic ev;
        ev = is_pwm ? match : (match || force_ev);
        wave_next = cur;
        if (com == 2'b01) begin
            if (ev && (!is_pwm || tog_ok)) begin
                wave_next = !cur;
            end
        end else if (com[1]) begin
            if (is_pwm && is_fast && top_hit) begin
                wave_next = !com[0];
            end else if (ev) begin
                wave_next = (is_pwm && !is_fast && !going_up) ? !com[0] : com[0];
            end
        end
    endfunction : wave_next

    // force acts on the output mode present now, never on flags or the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
        end else begin
            wave_a_q <= wave_next(wave_a_q, ctrl_a_q.out_mode_a, pwm, fast, dir_q == DIR_UP,
                                  match_a, top_ev, force_a, wgm[2]);
            wave_b_q <= wave_next(wave_b_q, ctrl_a_q.out_mode_b, pwm, fast, dir_q == DIR_UP,
                                  match_b, top_ev, force_b, 1'b0);
        end
    end

    assign wave_out_a = wave_a_q;
    assign wave_out_b = wave_b_q;
    assign wave_oe_a = ctrl_a_q.out_mode_a != 2'b00;
    assign wave_oe_b = ctrl_a_q.out_mode_b != 2'b00;

    // ****************************************************************
    // interrupt flags
    // ****************************************************************
    assign flag_set = tmr_irq_s'({match_b, match_a, ovf_ev});
    assign flag_clr = tmr_irq_s'((wr && (sel_flg || sel_clr)) ? pwdata[2:0] : 3'h0) | tmr_irq_s'(irq_ack);

    // a set in the same cycle as a clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= `TMR_IRQ_RST;
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    assign irq_req = flags_q & irq_en_q & {3{global_irq_en}};
    assign irq = |irq_req;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_force_a;
        (force_a && !pwm && ctrl_a_q.out_mode_a == 2'b01) |=> wave_a_q != $past(wave_a_q);
    endproperty
    a_force_a: assert property (p_force_a) else $error("force A did not toggle");

    property p_force_b;
        (force_b && !pwm && !match_b && ctrl_a_q.out_mode_b == 2'b11) |=> wave_b_q;
    endproperty
    a_force_b: assert property (p_force_b) else $error("force B did not set");

    property p_force_no_flag;
        (force_a && !match_a && !flags_q.cmp_a) |=> !flags_q.cmp_a;
    endproperty
    a_force_no_flag: assert property (p_force_no_flag) else $error("force set a flag");

    property p_force_pwm;
        (force_a && pwm && !match_a && !top_ev) |=> $stable(wave_a_q);
    endproperty
    a_force_pwm: assert property (p_force_pwm) else $error("force acted in pwm");

    property p_ctrl_b_read;
        (psel && !penable && !pwrite && sel_cb) |=> prdata[7:4] == 4'h0;
    endproperty
    a_ctrl_b_read: assert property (p_ctrl_b_read) else $error("control b high bits nonzero");

    property p_stopped;
        (ctrl_b_q.clk_select == 3'h0 && !wr_cnt) |=> count_q == $past(count_q);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped counter moved");

    property p_block;
        (wr_cnt && ctrl_b_q.clk_select == 3'h1) ##1 !wr_cnt |-> !match_a && !match_b;
    endproperty
    a_block: assert property (p_block) else $error("match after counter write");

    property p_cmp_b;
        (tick && !block_q && !wr_cnt && count_q == cmp_b_q) |=> flags_q.cmp_b;
    endproperty
    a_cmp_b: assert property (p_cmp_b) else $error("compare B flag missed");

    property p_ovf;
        (tick && wgm == 3'h0 && count_q == `TMR_MAX && !wr_cnt) |=> flags_q.ovf && count_q == `TMR_BOTTOM;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");

    property p_w1c;
        (wr && sel_flg && pwdata[0] && !ovf_ev) |=> !flags_q.ovf;
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");

    property p_ack;
        (irq_ack[1] && !match_a) |=> !flags_q.cmp_a;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge did not clear");

    property p_global;
        !global_irq_en |-> !irq;
    endproperty
    a_global: assert property (p_global) else $error("irq without global enable");

    property p_clear_mode;
        (match_a && !pwm && ctrl_a_q.out_mode_a == 2'b10) |=> !wave_a_q;
    endproperty
    a_clear_mode: assert property (p_clear_mode) else $error("clear on match failed");

    property p_phase_turn;
        (tick && phase && dir_q == DIR_UP && at_top && !wr_cnt) |=> dir_q == DIR_DOWN;
    endproperty
    a_phase_turn: assert property (p_phase_turn) else $error("no turn at top");

endmodule : tmr_timer2

// [tb/tmr_tb.sv]
/*
 * self-checking bench for the timer: apb register access, prescaler, compare, flags, force strobes.
 * assumes the design's zero-wait apb slave on pclk and timer_src_clock equal to pclk.
 */
`timescale 1ns/1ps
`include "tmr_map.svh"

module tb;
    import tmr_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic global_irq_en = 1'b0;
    logic [2:0] irq_ack = 3'h0;
    logic [2:0] irq_req;
    logic irq;
    logic wave_out_a;
    logic wave_oe_a;
    logic wave_out_b;
    logic wave_oe_b;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] q;
    logic e;
    logic prev;
    int divs [7] = '{1, 8, 32, 64, 128, 256, 1024};

    always #4 pclk = ~pclk;

    tmr_timer2 dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_irq_en(global_irq_en), .irq_ack(irq_ack), .irq_req(irq_req), .irq(irq),
        .wave_out_a(wave_out_a), .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b)
    );

    // ****************************************************************
    // verdict and timeout
    // ****************************************************************
    task stop_test;
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            stop_test();
        end
    end

    // ****************************************************************
    // comparisons
    // ****************************************************************
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task chk_rng(input string name, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
        checks++;
        if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
            err_count++;
            $display("[ERR] %s expected %h..%h seen %h", name, lo, hi, got);
        end
    endtask : chk_rng

    // ****************************************************************
    // apb master: called right after a rising edge, returns right after one
    // ****************************************************************
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr

    task rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, {24'h0, exp}, q);
    endtask : rd_chk

    task rd_rng(input logic [7:0] lo, input logic [7:0] hi);
        apb(1'b0, `TMR_OFF_COUNT, 32'h0);
        chk_rng("count", {24'h0, lo}, {24'h0, hi}, q);
    endtask : rd_rng

    task run(input logic [2:0] cs, input int n);
        wr(`TMR_OFF_CTRL_B, {5'h00, cs});
        repeat (n) @(posedge pclk);
        wr(`TMR_OFF_CTRL_B, 8'h00);
    endtask : run

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk("ctrl_b rst", `TMR_OFF_CTRL_B, 8'h00);
        rd_chk("irq_en rst", `TMR_OFF_IRQ_EN, 8'h00);
        rd_chk("flags rst", `TMR_OFF_FLAGS, 8'h00);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        chk("pready", 32'h1, {31'h0, pready});
        wr(`TMR_OFF_CTRL_B, 8'hf8);
        rd_chk("ctrl_b strobes", `TMR_OFF_CTRL_B, 8'h08);
        wr(`TMR_OFF_CTRL_B, 8'h00);
        wr(`TMR_OFF_COUNT, 8'h5a);
        rd_chk("count rw", `TMR_OFF_COUNT, 8'h5a);
        repeat (50) @(posedge pclk);
        rd_chk("count stopped", `TMR_OFF_COUNT, 8'h5a);
        // each tap gives eight ticks over eight periods, plus the access overhead
        for (int i = 0; i < 7; i++) begin
            wr(`TMR_OFF_COUNT, 8'h00);
            run(3'(i + 1), 8 * divs[i]);
            rd_rng(8'h07, 8'h0b);
        end
        wr(`TMR_OFF_FLAG_CLR, 8'h07);
        wr(`TMR_OFF_CMP_A, 8'h10);
        wr(`TMR_OFF_CMP_B, 8'h20);
        wr(`TMR_OFF_COUNT, 8'h00);
        run(3'h1, 60);
        rd_chk("flags match", `TMR_OFF_FLAGS, 8'h06);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`TMR_OFF_IRQ_EN, 8'h02);
        global_irq_en <= 1'b1;
        @(posedge pclk);
        chk("irq_req", 32'h2, {29'h0, irq_req});
        chk("irq", 32'h1, {31'h0, irq});
        global_irq_en <= 1'b0;
        @(posedge pclk);
        chk("irq global off", 32'h0, {31'h0, irq});
        wr(`TMR_OFF_FLAGS, 8'h02);
        rd_chk("flags w1c", `TMR_OFF_FLAGS, 8'h04);
        wr(`TMR_OFF_FLAGS, 8'h00);
        rd_chk("flags w0", `TMR_OFF_FLAGS, 8'h04);
        wr(`TMR_OFF_FLAG_CLR, 8'h04);
        rd_chk("flags clr reg", `TMR_OFF_FLAGS, 8'h00);
        wr(`TMR_OFF_COUNT, 8'hfe);
        run(3'h1, 4);
        rd_chk("ovf set", `TMR_OFF_FLAGS, 8'h01);
        irq_ack <= 3'h7;
        @(posedge pclk);
        irq_ack <= 3'h0;
        rd_chk("ack clear", `TMR_OFF_FLAGS, 8'h00);
        // written count equal to compare a: first tick must not match
        wr(`TMR_OFF_COUNT, 8'h10);
        run(3'h1, 6);
        rd_chk("match blocked", `TMR_OFF_FLAGS, 8'h00);
        wr(`TMR_OFF_COUNT, 8'h0f);
        run(3'h1, 6);
        rd_chk("match after", `TMR_OFF_FLAGS, 8'h02);
        wr(`TMR_OFF_FLAG_CLR, 8'h07);
        // count written to compare a while running: the next tick must not match
        wr(`TMR_OFF_CTRL_B, 8'h01);
        wr(`TMR_OFF_COUNT, 8'h10);
        wr(`TMR_OFF_CTRL_B, 8'h00);
        rd_chk("running write blocked", `TMR_OFF_FLAGS, 8'h00);
        // force strobes in ctc mode, timer stopped
        wr(`TMR_OFF_COUNT, 8'h20);
        wr(`TMR_OFF_CTRL_A, 8'h72);
        prev = wave_out_a;
        wr(`TMR_OFF_CTRL_B, 8'hc0);
        @(posedge pclk);
        chk("force toggle a", {31'h0, ~prev}, {31'h0, wave_out_a});
        chk("force set b", 32'h1, {31'h0, wave_out_b});
        chk("oe on", 32'h3, {30'h0, wave_oe_a, wave_oe_b});
        rd_chk("force no flag", `TMR_OFF_FLAGS, 8'h00);
        rd_chk("force no clear", `TMR_OFF_COUNT, 8'h20);
        wr(`TMR_OFF_CTRL_A, 8'ha2);
        wr(`TMR_OFF_CTRL_B, 8'hc0);
        @(posedge pclk);
        chk("force clear", 32'h0, {30'h0, wave_out_a, wave_out_b});
        wr(`TMR_OFF_CTRL_A, 8'hf2);
        wr(`TMR_OFF_CTRL_B, 8'hc0);
        @(posedge pclk);
        chk("force set", 32'h3, {30'h0, wave_out_a, wave_out_b});
        // phase pwm: strobes ignored, outputs hold
        wr(`TMR_OFF_CTRL_A, 8'ha1);
        wr(`TMR_OFF_CTRL_B, 8'hc0);
        @(posedge pclk);
        chk("pwm force ignored", 32'h3, {30'h0, wave_out_a, wave_out_b});
        wr(`TMR_OFF_CTRL_A, 8'h01);
        chk("oe off", 32'h0, {30'h0, wave_oe_a, wave_oe_b});
        wr(`TMR_OFF_FLAG_CLR, 8'h07);
        wr(`TMR_OFF_COUNT, 8'hf0);
        run(3'h1, 40);
        rd_rng(8'hc0, 8'hfe);
        rd_chk("no ovf at top", `TMR_OFF_FLAGS, 8'h00);
        run(3'h1, 260);
        apb(1'b0, `TMR_OFF_FLAGS, 32'h0);
        chk("ovf at bottom", 32'h1, {31'h0, q[0]});
        wr(`TMR_OFF_FLAGS, 8'h01);
        apb(1'b0, `TMR_OFF_FLAGS, 32'h0);
        chk("ovf w1c", 32'h0, {31'h0, q[0]});
        // ctc with top at compare a never reaches max; pin a clears on match
        wr(`TMR_OFF_CTRL_A, 8'h82);
        wr(`TMR_OFF_CMP_A, 8'h30);
        wr(`TMR_OFF_FLAG_CLR, 8'h07);
        wr(`TMR_OFF_COUNT, 8'h00);
        run(3'h1, 200);
        rd_rng(8'h00, 8'h30);
        apb(1'b0, `TMR_OFF_FLAGS, 32'h0);
        chk("ctc no ovf", 32'h0, {31'h0, q[0]});
        chk("ctc match a", 32'h1, {31'h0, q[1]});
        chk("ctc clear a", 32'h0, {31'h0, wave_out_a});
        stop_test();
    end
endmodule : tb
